// File: hdl/mdb_bridge.sv
// multidrop polling bridge: auto and manual polling engine with result framing
// Overview of operation
// - serve readers with identifiers 1 to 31
// - host link carries ascii characters only
// - auto polling queries registered readers, forwards results
// - frame: header, %P, two digits, dash, data, terminator
// - header esc/stx/none/user string, terminator cr/crlf/etx/user string
// - manual reply carries nodata/overflow/absent/link error code
// - poll form %Pmm cr or stx..etx, lf allowed
// - leading esc discards host receive buffer
// - manual polling only while no identifier registered
// - default format 9600 bps, 7 bits, even, 1 stop
// - reader link may run at 38400 bps
module mdb_bridge
	import mdb_pkg::*;
#(
	parameter int BAUD_DIV_DEF = CLK_HZ / BAUD_DEF, // cycles per bit at the default rate
	parameter int BAUD_DIV_FAST = CLK_HZ / BAUD_FAST // cycles per bit at the fast reader rate
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [31:0] i_id_registered,
	input wire logic [1:0] i_hdr_sel,
	input wire logic [1:0] i_trm_sel,
	input wire logic [39:0] i_hdr_user,
	input wire logic [2:0] i_hdr_user_len,
	input wire logic [39:0] i_trm_user,
	input wire logic [2:0] i_trm_user_len,
	input wire logic i_link_fast,
	input wire logic i_host_rx_valid,
	input wire logic [7:0] i_host_rx_data,
	output logic o_host_rx_ready,
	output logic o_host_rx_flush,
	output logic o_poll_reject,
	output logic o_host_tx_valid,
	output logic [7:0] o_host_tx_data,
	input wire logic i_host_tx_ready,
	output logic o_rdr_req_valid,
	output logic [4:0] o_rdr_req_id,
	input wire logic i_rdr_req_ready,
	input wire logic i_rdr_stat_valid,
	input wire logic [2:0] i_rdr_stat,
	output logic o_rdr_stat_ready,
	input wire logic i_rdr_rsp_valid,
	input wire logic [7:0] i_rdr_rsp_data,
	input wire logic i_rdr_rsp_last,
	output logic o_rdr_rsp_ready,
	output logic o_auto_mode,
	output logic [15:0] o_host_baud_div,
	output logic [15:0] o_link_baud_div
);
	typedef enum logic [6:0] {S_IDLE = 7'h01, S_ASK = 7'h02, S_WAIT = 7'h04, S_HDR = 7'h08, S_PFX = 7'h10,
		S_BODY = 7'h20, S_TRM = 7'h40} mdb_est_t;
	typedef struct packed {
		mdb_est_t st; // frame position
		logic [4:0] id; // reader being served
		logic [2:0] idx; // character index inside the current part
		mdb_stat_t stat; // answer status of the reader
		logic tx_v; // output character waiting
		logic [7:0] tx_d; // output character
	} mdb_estate_t;

	mdb_estate_t q_ff;
	mdb_estate_t nxt_q;
	mdb_poll_if poll ();
	logic free; // output slot can take a character now
	logic [2:0] hlen; // header length
	logic [2:0] tlen; // terminator length
	logic [39:0] code; // reply code text
	logic [2:0] clen; // reply code length
	logic [1:0] tens; // tens digit of the identifier
	logic [3:0] ones; // ones digit of the identifier

	// picks character i of a five-character string, first char in the top byte
	function automatic logic [7:0] str_char(input logic [39:0] s, input logic [2:0] i);
		str_char = 8'h00;
		for (int k = 0; k < 5; k++) begin
			if (i == 3'(k)) begin
				str_char = s[39 - 8 * k -: 8];
			end
		end
	endfunction : str_char

	// next registered identifier after cur, wrapping 31 to 1
	function automatic logic [4:0] next_id(input logic [31:0] m, input logic [4:0] cur);
		int base;
		int c;
		base = (cur == 5'h00) ? ID_COUNT : int'(cur);
		next_id = cur;
		for (int k = ID_COUNT; k >= 1; k--) begin
			c = ((base - 1 + k) % ID_COUNT) + 1;
			if (m[c]) begin
				next_id = 5'(c); // lowest k wins as loop runs downward
			end
		end
	endfunction : next_id

	mdb_cmd_parser u_parser (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_rx_valid(i_host_rx_valid),
		.i_rx_data(i_host_rx_data),
		.o_rx_ready(o_host_rx_ready),
		.poll(poll.parser)
	);

	// bit 0 has no reader behind it and is never polled
	assign o_auto_mode = |i_id_registered[31:1];
	assign o_host_rx_flush = poll.flush;
	assign o_poll_reject = poll.reject;
	// manual polls are consumed only when idle; in auto mode they are dropped
	assign poll.ack = (q_ff.st == S_IDLE) && poll.req;
	assign free = !q_ff.tx_v || i_host_tx_ready;
	assign o_host_tx_valid = q_ff.tx_v;
	assign o_host_tx_data = q_ff.tx_d;
	assign o_rdr_req_valid = (q_ff.st == S_ASK);
	assign o_rdr_req_id = q_ff.id;
	assign o_rdr_stat_ready = (q_ff.st == S_WAIT);
	// reader data is pulled only as fast as the host side drains it
	assign o_rdr_rsp_ready = (q_ff.st == S_BODY) && (q_ff.stat == ST_DATA) && free;
	// the uart outside runs the default format unless the reader link is sped up
	assign o_host_baud_div = 16'(BAUD_DIV_DEF);
	assign o_link_baud_div = i_link_fast ? 16'(BAUD_DIV_FAST) : 16'(BAUD_DIV_DEF);
	assign tens = (q_ff.id >= 5'h1e) ? 2'h3 : (q_ff.id >= 5'h14) ? 2'h2 : (q_ff.id >= 5'h0a) ? 2'h1 : 2'h0;
	assign ones = 4'(q_ff.id - 5'(tens) * 5'h0a);

	// lengths and code text for the selected framing
	always_comb begin
		unique case (mdb_hdr_t'(i_hdr_sel))
			HDR_NONE: hlen = 3'h0;
			HDR_ESC, HDR_STX: hlen = 3'h1;
			HDR_USER: hlen = (i_hdr_user_len > STR_MAX) ? STR_MAX : i_hdr_user_len;
		endcase
		unique case (mdb_trm_t'(i_trm_sel))
			TRM_CR, TRM_ETX: tlen = 3'h1;
			TRM_CRLF: tlen = 3'h2;
			TRM_USER: tlen = (i_trm_user_len > STR_MAX) ? STR_MAX : i_trm_user_len;
		endcase
		code = link_error_code; // unknown status is reported as a link fault
		clen = LEN_LINKERR;
		case (q_ff.stat)
			ST_NODATA: begin
				code = CODE_NODATA;
				clen = LEN_NODATA;
			end
			ST_OVER: begin
				code = CODE_OVER;
				clen = LEN_OVER;
			end
			ST_ABSENT: begin
				code = CODE_ABSENT;
				clen = LEN_ABSENT;
			end
			default: begin
				code = link_error_code;
				clen = LEN_LINKERR;
			end
		endcase
	end

	// frame engine: one character per cycle into the output slot
	always_comb begin
		nxt_q = q_ff;
		if (i_host_tx_ready) begin
			nxt_q.tx_v = 1'b0;
		end
		unique case (q_ff.st)
			S_IDLE: begin
				if (o_auto_mode) begin
					nxt_q.id = next_id(i_id_registered, q_ff.id);
					nxt_q.st = S_ASK;
				end else if (poll.req) begin
					nxt_q.id = poll.id;
					nxt_q.st = S_ASK;
				end
			end
			S_ASK: begin
				if (i_rdr_req_ready) begin
					nxt_q.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (i_rdr_stat_valid) begin
					nxt_q.stat = mdb_stat_t'(i_rdr_stat);
					nxt_q.idx = 3'h0;
					// an empty reader in auto mode gives nothing to forward
					nxt_q.st = (o_auto_mode && i_rdr_stat == ST_NODATA) ? S_IDLE : S_HDR;
				end
			end
			S_HDR: begin
				if (q_ff.idx >= hlen) begin
					nxt_q.st = S_PFX;
					nxt_q.idx = 3'h0;
				end else if (free) begin
					nxt_q.tx_v = 1'b1;
					nxt_q.tx_d = (i_hdr_sel == HDR_ESC) ? CH_ESC : (i_hdr_sel == HDR_STX) ? CH_STX
						: str_char(i_hdr_user, q_ff.idx) & ASCII_MASK;
					nxt_q.idx = q_ff.idx + 3'h1;
				end
			end
			S_PFX: begin
				if (free) begin
					nxt_q.tx_v = 1'b1;
					unique case (q_ff.idx)
						3'h0: nxt_q.tx_d = CH_PCT;
						3'h1: nxt_q.tx_d = CH_P;
						3'h2: nxt_q.tx_d = CH_ZERO + 8'(tens);
						3'h3: nxt_q.tx_d = CH_ZERO + 8'(ones);
						default: nxt_q.tx_d = CH_DASH;
					endcase
					nxt_q.idx = (q_ff.idx == PFX_LAST) ? 3'h0 : q_ff.idx + 3'h1;
					nxt_q.st = (q_ff.idx == PFX_LAST) ? S_BODY : S_PFX;
				end
			end
			S_BODY: begin
				if (q_ff.stat == ST_DATA) begin
					if (free && i_rdr_rsp_valid) begin
						nxt_q.tx_v = 1'b1;
						nxt_q.tx_d = i_rdr_rsp_data & ASCII_MASK;
						nxt_q.st = i_rdr_rsp_last ? S_TRM : S_BODY;
					end
				end else if (free) begin
					nxt_q.tx_v = 1'b1;
					nxt_q.tx_d = str_char(code, q_ff.idx);
					nxt_q.idx = (q_ff.idx == clen - 3'h1) ? 3'h0 : q_ff.idx + 3'h1;
					nxt_q.st = (q_ff.idx == clen - 3'h1) ? S_TRM : S_BODY;
				end
			end
			S_TRM: begin
				if (q_ff.idx >= tlen) begin
					nxt_q.st = S_IDLE;
					nxt_q.idx = 3'h0;
				end else if (free) begin
					nxt_q.tx_v = 1'b1;
					unique case (mdb_trm_t'(i_trm_sel))
						TRM_CR: nxt_q.tx_d = CH_CR;
						TRM_CRLF: nxt_q.tx_d = (q_ff.idx == 3'h0) ? CH_CR : CH_LF;
						TRM_ETX: nxt_q.tx_d = CH_ETX;
						TRM_USER: nxt_q.tx_d = str_char(i_trm_user, q_ff.idx) & ASCII_MASK;
					endcase
					nxt_q.idx = q_ff.idx + 3'h1;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q_ff <= '{st: S_IDLE, id: 5'h00, idx: 3'h0, stat: ST_DATA, tx_v: 1'b0, tx_d: 8'h00};
		end else begin
			q_ff <= nxt_q;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_pct_sent;
		q_ff.st == S_PFX && q_ff.idx == 3'h0 && free;
	endsequence
	sequence s_p_follows;
		##[1:8] (o_host_tx_valid && o_host_tx_data == CH_P);
	endsequence
	a_pfx_order: assert property (s_pct_sent |=> o_host_tx_data == CH_PCT ##0 s_p_follows)
		else $error("frame prefix out of order");
	a_id_range: assert property (o_rdr_req_valid |-> o_rdr_req_id >= ID_MIN && o_rdr_req_id <= ID_MAX)
		else $error("reader id out of range");
	a_auto_registered: assert property (o_rdr_req_valid && o_auto_mode |-> i_id_registered[o_rdr_req_id])
		else $error("unregistered reader polled");
	a_auto_skip: assert property (o_rdr_stat_ready && i_rdr_stat_valid && o_auto_mode && i_rdr_stat == ST_NODATA
		|=> q_ff.st == S_IDLE)
		else $error("empty reader forwarded in auto mode");
	a_manual_absent: assert property (o_rdr_stat_ready && i_rdr_stat_valid && !o_auto_mode && i_rdr_stat == ST_ABSENT
		|-> ##[2:300] (o_host_tx_valid && o_host_tx_data == 8'h4e))
		else $error("absent code not sent");
	a_ascii_out: assert property (o_host_tx_valid |-> !o_host_tx_data[7])
		else $error("non-ascii character sent");
	a_tx_hold: assert property (o_host_tx_valid && !i_host_tx_ready |=> o_host_tx_valid && $stable(o_host_tx_data))
		else $error("output character dropped");
	a_manual_only: assert property (poll.req && q_ff.st == S_IDLE && o_auto_mode |=> o_rdr_req_id != poll.id
		|| i_id_registered[o_rdr_req_id])
		else $error("manual poll served in auto mode");
endmodule : mdb_bridge

// File: hdl/mdb_cmd_parser.sv
// host poll command parser: checks framing and identifier before handing a poll on
module mdb_cmd_parser
	import mdb_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_ready,
	mdb_poll_if.parser poll
);
	typedef enum logic [5:0] {P_IDLE = 6'h01, P_LETTER = 6'h02, P_D1 = 6'h04, P_D2 = 6'h08, P_END = 6'h10,
		P_HOLD = 6'h20} mdb_pst_t;
	typedef struct packed {
		mdb_pst_t st; // parse position
		logic stx; // frame opened with stx, so it must close with etx
		logic [1:0] tens; // first digit
		logic [4:0] id; // assembled identifier
		logic flush; // discard pulse
		logic rej; // reject pulse
	} mdb_pstate_t;

	mdb_pstate_t q_ff;
	mdb_pstate_t nxt_q;
	logic take; // a character is consumed this cycle
	logic [3:0] dig; // digit value of the character
	logic is_dig; // character is a decimal digit
	logic [5:0] id_sum; // identifier from both digits, wide enough for 39

	// the parser holds chars back only while a finished poll waits for the engine
	assign o_rx_ready = (q_ff.st != P_HOLD);
	assign take = i_rx_valid && o_rx_ready;
	assign dig = 4'(i_rx_data - CH_ZERO);
	// a bare range test on dig would let '@' and friends pass as digits
	assign is_dig = (i_rx_data >= CH_ZERO) && (i_rx_data <= CH_NINE);
	// six bits so that 32..39 cannot wrap back into the legal range
	assign id_sum = 6'(q_ff.tens) * 6'h0a + 6'(dig);
	assign poll.req = (q_ff.st == P_HOLD);
	assign poll.id = q_ff.id;
	assign poll.flush = q_ff.flush;
	assign poll.reject = q_ff.rej;

	// next-state of the parse
	always_comb begin
		nxt_q = q_ff;
		nxt_q.flush = 1'b0;
		nxt_q.rej = 1'b0;
		if (take && i_rx_data == CH_ESC) begin
			nxt_q.flush = 1'b1;
			nxt_q.st = P_IDLE; // partial frame goes with the buffer
			nxt_q.stx = 1'b0;
		end else if (take && i_rx_data[7]) begin
			nxt_q.rej = 1'b1;
			nxt_q.st = P_IDLE;
			nxt_q.stx = 1'b0;
		end else if (take) begin
			unique case (q_ff.st)
				P_IDLE: begin
					if (i_rx_data == CH_STX) begin
						nxt_q.stx = 1'b1;
					end else if (i_rx_data == CH_PCT) begin
						nxt_q.st = P_LETTER;
					end else if (i_rx_data != CH_LF && i_rx_data != CH_CR && i_rx_data != CH_ETX) begin
						nxt_q.rej = 1'b1; // stray char; trailing lf is tolerated silently
						nxt_q.stx = 1'b0;
					end
				end
				P_LETTER: begin
					nxt_q.st = (i_rx_data == CH_P) ? P_D1 : P_IDLE;
					nxt_q.rej = (i_rx_data != CH_P);
				end
				P_D1: begin
					// only 0..3 can lead a legal identifier
					nxt_q.st = (is_dig && dig <= 4'h3) ? P_D2 : P_IDLE;
					nxt_q.rej = !(is_dig && dig <= 4'h3);
					nxt_q.tens = dig[1:0];
				end
				P_D2: begin
					nxt_q.st = (is_dig && id_sum <= 6'(ID_MAX)) ? P_END : P_IDLE;
					nxt_q.rej = !(is_dig && id_sum <= 6'(ID_MAX));
					nxt_q.id = 5'(id_sum);
				end
				P_END: begin
					if ((q_ff.stx ? i_rx_data == CH_ETX : i_rx_data == CH_CR)
						&& q_ff.id >= ID_MIN && q_ff.id <= ID_MAX) begin
						nxt_q.st = P_HOLD;
					end else begin
						nxt_q.st = P_IDLE;
						nxt_q.rej = 1'b1;
					end
					nxt_q.stx = 1'b0;
				end
				P_HOLD: begin
					nxt_q.st = P_HOLD;
				end
			endcase
		end else if (q_ff.st == P_HOLD && poll.ack) begin
			nxt_q.st = P_IDLE;
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q_ff <= '{st: P_IDLE, stx: 1'b0, tens: 2'h0, id: 5'h00, flush: 1'b0, rej: 1'b0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_esc_flush: assert property (take && i_rx_data == CH_ESC |=> poll.flush && q_ff.st == P_IDLE)
		else $error("esc did not flush");
	a_poll_closer: assert property ($rose(poll.req) |-> $past(i_rx_data) == CH_CR || $past(i_rx_data) == CH_ETX)
		else $error("poll raised without cr or etx");
	a_id_checked: assert property (poll.req |-> poll.id >= ID_MIN && poll.id <= ID_MAX)
		else $error("out of range poll id");
	a_bad_digit: assert property (take && q_ff.st == P_D1 && i_rx_data == 8'h34 |=> poll.reject ##1 !poll.req)
		else $error("bad digit not rejected");
endmodule : mdb_cmd_parser

// File: hdl/mdb_pkg.sv
// shared constants and types of the multidrop polling bridge
package mdb_pkg;
	// control characters and frame characters (7-bit ascii)
	localparam logic [7:0] CH_ESC = 8'h1b;
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_PCT = 8'h25;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_DASH = 8'h2d;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] ASCII_MASK = 8'h7f;
	// reader identifier range on the shared link
	localparam logic [4:0] ID_MIN = 5'h01;
	localparam logic [4:0] ID_MAX = 5'h1f;
	localparam int ID_COUNT = 31;
	// fixed part of a result frame: '%' 'P' tens ones '-'
	localparam logic [2:0] PFX_LAST = 3'h4;
	localparam logic [2:0] STR_MAX = 3'h5;
	// reply codes, first character in the top byte
	localparam logic [39:0] CODE_NODATA = 40'h4552524f52;
	localparam logic [2:0] LEN_NODATA = 3'h5;
	localparam logic [39:0] CODE_OVER = 40'h4f56455200;
	localparam logic [2:0] LEN_OVER = 3'h4;
	localparam logic [39:0] CODE_ABSENT = 40'h4e43000000;
	localparam logic [2:0] LEN_ABSENT = 3'h2;
	localparam logic [39:0] link_error_code = 40'h5345525200;
	localparam logic [2:0] LEN_LINKERR = 3'h4;
	// serial character format
	localparam int CLK_HZ = 50000000;
	localparam int BAUD_DEF = 9600;
	localparam int BAUD_FAST = 38400;
	localparam int DATA_BITS = 7;
	localparam int STOP_BITS = 1;
	localparam logic PARITY_EVEN = 1'b1;
	// header and terminator selections
	typedef enum logic [1:0] {HDR_NONE = 2'h0, HDR_ESC = 2'h1, HDR_STX = 2'h2, HDR_USER = 2'h3} mdb_hdr_t;
	typedef enum logic [1:0] {TRM_CR = 2'h0, TRM_CRLF = 2'h1, TRM_ETX = 2'h2, TRM_USER = 2'h3} mdb_trm_t;
	// reader answer status
	typedef enum logic [2:0] {ST_DATA = 3'h0, ST_NODATA = 3'h1, ST_OVER = 3'h2, ST_ABSENT = 3'h3,
		ST_LINKERR = 3'h4} mdb_stat_t;
endpackage : mdb_pkg

// File: hdl/mdb_poll_if.sv
// poll request carrier between command parser and polling engine
interface mdb_poll_if;
	logic req; // parsed poll waiting for the engine
	logic [4:0] id; // validated reader identifier
	logic ack; // engine took the poll
	logic flush; // pulse: host receive buffer discarded
	logic reject; // pulse: malformed poll dropped
	modport parser (output req, output id, output flush, output reject, input ack);
	modport engine (input req, input id, input flush, input reject, output ack);
endinterface : mdb_poll_if

// File: testbench/mdb_rdr_model.sv
// behavioural reader on the shared link, answering one poll at a time
module mdb_rdr_model
	import mdb_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_req_valid,
	input wire logic [4:0] i_req_id,
	output logic o_req_ready,
	output logic o_stat_valid,
	output logic [2:0] o_stat,
	input wire logic i_stat_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	output logic o_rsp_last,
	input wire logic i_rsp_ready,
	input wire logic [2:0] i_ans_stat,
	input wire logic [39:0] i_ans_data,
	input wire logic [2:0] i_ans_len,
	input wire logic [1:0] i_ans_wait
);
	timeunit 1ns;
	timeprecision 1ns;
	int k; // index of the data character in flight
	// one reader answers every identifier, so no two answers ever collide
	initial begin
		o_req_ready = 1'b0;
		o_stat_valid = 1'b0;
		o_stat = 3'h0;
		o_rsp_valid = 1'b0;
		o_rsp_data = 8'h00;
		o_rsp_last = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_req_valid === 1'b1) begin
				#1 o_req_ready = 1'b1;
				@(posedge i_clk);
				#1 o_req_ready = 1'b0;
				// a slow reader takes a few cycles before it answers
				repeat (i_ans_wait) @(posedge i_clk);
				#1 o_stat_valid = 1'b1;
				o_stat = i_ans_stat;
				do @(posedge i_clk); while (i_stat_ready !== 1'b1);
				#1 o_stat_valid = 1'b0;
				o_stat = ~o_stat; // released status no longer shows the answer
				// headerless body: raw characters only
				for (k = 0; k < ((i_ans_stat == ST_DATA) ? int'(i_ans_len) : 0); k++) begin
					o_rsp_valid = 1'b1;
					o_rsp_data = i_ans_data[39 - 8 * k -: 8];
					o_rsp_last = (k == int'(i_ans_len) - 1);
					do @(posedge i_clk); while (i_rsp_ready !== 1'b1);
					// valid stays up between beats, so it never drops and rises in one step
					#1;
				end
				o_rsp_valid = 1'b0;
				o_rsp_data = ~o_rsp_data;
				o_rsp_last = 1'b0;
			end
		end
	end
endmodule : mdb_rdr_model

// File: testbench/tb.sv
// self-checking bench of the multidrop polling bridge
module tb
	import mdb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [7:0] mdb_bq_t[$]; // character stream
	logic i_clk, i_reset_n, i_link_fast, i_host_rx_valid, i_host_tx_ready;
	logic [31:0] i_id_registered;
	logic [1:0] i_hdr_sel, i_trm_sel, ans_wait;
	logic [39:0] i_hdr_user, i_trm_user, ans_data;
	logic [2:0] i_hdr_user_len, i_trm_user_len, ans_stat, ans_len;
	logic [7:0] i_host_rx_data, o_host_tx_data, i_rdr_rsp_data;
	logic o_host_rx_ready, o_host_rx_flush, o_poll_reject, o_host_tx_valid, o_rdr_req_valid;
	logic i_rdr_req_ready, i_rdr_stat_valid, o_rdr_stat_ready, i_rdr_rsp_valid, i_rdr_rsp_last, o_rdr_rsp_ready;
	logic [4:0] o_rdr_req_id;
	logic [2:0] i_rdr_stat;
	logic o_auto_mode;
	logic [15:0] o_host_baud_div, o_link_baud_div, lfsr;
	mdb_bq_t rxq; // characters seen leaving towards the host
	int n_fail, cmp_count, n_rej, n_flush, n_req, id, r0, q0, f0;
	mdb_bridge i_mdb_bridge (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_id_registered(i_id_registered),
		.i_hdr_sel(i_hdr_sel), .i_trm_sel(i_trm_sel), .i_hdr_user(i_hdr_user), .i_hdr_user_len(i_hdr_user_len),
		.i_trm_user(i_trm_user), .i_trm_user_len(i_trm_user_len), .i_link_fast(i_link_fast),
		.i_host_rx_valid(i_host_rx_valid), .i_host_rx_data(i_host_rx_data), .o_host_rx_ready(o_host_rx_ready),
		.o_host_rx_flush(o_host_rx_flush), .o_poll_reject(o_poll_reject), .o_host_tx_valid(o_host_tx_valid),
		.o_host_tx_data(o_host_tx_data), .i_host_tx_ready(i_host_tx_ready), .o_rdr_req_valid(o_rdr_req_valid),
		.o_rdr_req_id(o_rdr_req_id), .i_rdr_req_ready(i_rdr_req_ready), .i_rdr_stat_valid(i_rdr_stat_valid),
		.i_rdr_stat(i_rdr_stat), .o_rdr_stat_ready(o_rdr_stat_ready), .i_rdr_rsp_valid(i_rdr_rsp_valid),
		.i_rdr_rsp_data(i_rdr_rsp_data), .i_rdr_rsp_last(i_rdr_rsp_last), .o_rdr_rsp_ready(o_rdr_rsp_ready),
		.o_auto_mode(o_auto_mode), .o_host_baud_div(o_host_baud_div), .o_link_baud_div(o_link_baud_div));
	mdb_rdr_model i_mdb_rdr_model (.i_clk(i_clk), .i_req_valid(o_rdr_req_valid), .i_req_id(o_rdr_req_id),
		.o_req_ready(i_rdr_req_ready), .o_stat_valid(i_rdr_stat_valid), .o_stat(i_rdr_stat),
		.i_stat_ready(o_rdr_stat_ready), .o_rsp_valid(i_rdr_rsp_valid), .o_rsp_data(i_rdr_rsp_data),
		.o_rsp_last(i_rdr_rsp_last), .i_rsp_ready(o_rdr_rsp_ready), .i_ans_stat(ans_stat), .i_ans_data(ans_data),
		.i_ans_len(ans_len), .i_ans_wait(ans_wait));
	// 50 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// fixed-seed generator, so every run sees the same stream
	function automatic int rnd(int n);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return int'(lfsr) % n;
	endfunction : rnd
	// five random upper-case letters
	function automatic logic [39:0] rnd_str();
		logic [39:0] s;
		for (int i = 0; i < 5; i++) s = {s[31:0], 8'h41 + 8'(rnd(26))};
		return s;
	endfunction : rnd_str
	// appends the first n characters of a string
	function automatic void put(inout mdb_bq_t q, input logic [39:0] s, input int n);
		for (int i = 0; i < n; i++) q.push_back(s[39 - 8 * i -: 8]);
	endfunction : put
	// expected host frame for one reader answer
	function automatic mdb_bq_t exp_frame(int rid, logic [2:0] st);
		mdb_bq_t q;
		q = {};
		case (i_hdr_sel)
			2'h1: q.push_back(CH_ESC);
			2'h2: q.push_back(CH_STX);
			2'h3: put(q, i_hdr_user, int'(i_hdr_user_len));
			default: ;
		endcase
		q = {q, CH_PCT, CH_P, CH_ZERO + 8'(rid / 10), CH_ZERO + 8'(rid % 10), CH_DASH};
		case (st)
			3'h0: put(q, ans_data, int'(ans_len));
			3'h1: put(q, CODE_NODATA, int'(LEN_NODATA));
			3'h2: put(q, CODE_OVER, int'(LEN_OVER));
			3'h3: put(q, CODE_ABSENT, int'(LEN_ABSENT));
			default: put(q, link_error_code, int'(LEN_LINKERR));
		endcase
		case (i_trm_sel)
			2'h0: q.push_back(CH_CR);
			2'h1: q = {q, CH_CR, CH_LF};
			2'h2: q.push_back(CH_ETX);
			default: put(q, i_trm_user, int'(i_trm_user_len));
		endcase
		return q;
	endfunction : exp_frame
	// closing report, the single end of the run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// compares one value and counts the outcome
	task automatic check(logic [39:0] seen, logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// offers characters back to back, each held until taken
	task automatic send_str(mdb_bq_t s);
		int n;
		foreach (s[i]) begin
			@(negedge i_clk);
			i_host_rx_valid = 1'b1;
			i_host_rx_data = s[i];
			for (n = 0; o_host_rx_ready !== 1'b1 && n < 500; n++) @(negedge i_clk);
			if (n >= 500) begin
				n_fail++;
				final_report();
			end
			@(posedge i_clk);
		end
		@(negedge i_clk);
		i_host_rx_valid = 1'b0;
	endtask : send_str
	// waits for a whole frame, then compares it character by character
	task automatic check_frame(mdb_bq_t e);
		int n;
		for (n = 0; rxq.size() < e.size() && n < 3000; n++) @(posedge i_clk);
		if (n >= 3000) begin
			n_fail++;
			final_report();
		end
		foreach (e[i]) check(rxq.pop_front(), e[i]);
	endtask : check_frame
	// framing and answer setup for one case
	task automatic cfg(int k);
		@(negedge i_clk);
		i_hdr_sel = 2'(k % 4);
		i_trm_sel = 2'((k + 1) % 4);
		i_hdr_user = rnd_str();
		i_hdr_user_len = 3'(1 + rnd(5));
		i_trm_user = rnd_str();
		i_trm_user_len = 3'(1 + rnd(5));
		// case 9 gives an undefined status, which must come out as a link error
		ans_stat = (k < 5) ? 3'(k) : (k == 9) ? 3'h6 : ST_DATA;
		ans_data = rnd_str();
		ans_len = 3'(1 + rnd(5));
		ans_wait = 2'(rnd(4));
	endtask : cfg
	// host side stalls at random
	always @(negedge i_clk) i_host_tx_ready <= (rnd(4) != 0);
	// monitors of accepted characters and pulses
	always @(posedge i_clk) begin
		if (o_host_tx_valid === 1'b1 && i_host_tx_ready === 1'b1) rxq.push_back(o_host_tx_data);
		if (o_poll_reject === 1'b1) n_rej++;
		if (o_host_rx_flush === 1'b1) n_flush++;
		if (o_rdr_req_valid === 1'b1 && i_rdr_req_ready === 1'b1) n_req++;
	end
	// main sequence
	initial begin
		lfsr = 16'h42c5;
		{n_fail, cmp_count, n_rej, n_flush, n_req} = '0;
		{i_reset_n, i_link_fast, i_host_rx_valid, i_host_rx_data, i_id_registered} = '0;
		i_host_tx_ready = 1'b1;
		cfg(0);
		repeat (8) @(posedge i_clk);
		check(o_host_rx_ready, 1'b1);
		check(o_rdr_req_valid, 1'b0);
		check(o_host_tx_valid, 1'b0);
		check(o_host_baud_div, 16'(CLK_HZ / BAUD_DEF));
		check(o_link_baud_div, 16'(CLK_HZ / BAUD_DEF));
		@(negedge i_clk);
		i_reset_n = 1'b1;
		i_link_fast = 1'b1;
		i_id_registered = 32'h0000_0001;
		@(negedge i_clk);
		check(o_link_baud_div, 16'(CLK_HZ / BAUD_FAST));
		check(o_auto_mode, 1'b0);
		// manual polls over every header, terminator, status and command form
		for (int k = 0; k < 10; k++) begin
			cfg(k);
			// ending on 31 makes auto polling start from the lowest registered id
			id = (k == 0) ? 1 : (k == 9) ? 31 : 1 + rnd(31);
			f0 = n_flush;
			if (k == 2) begin
				send_str({CH_ESC, CH_PCT, CH_P});
			end else if (k % 2) begin
				send_str({CH_STX, CH_PCT, CH_P});
			end else begin
				send_str({CH_PCT, CH_P});
			end
			send_str({CH_ZERO + 8'(id / 10), CH_ZERO + 8'(id % 10), (k % 2) ? CH_ETX : CH_CR});
			if (k == 1 || k == 4) send_str({CH_LF});
			check_frame(exp_frame(id, ans_stat));
			check(n_flush - f0, (k == 2) ? 1 : 0);
		end
		// malformed polls never reach the reader link
		r0 = n_rej;
		q0 = n_req;
		send_str({CH_PCT, CH_P, CH_ZERO, CH_ZERO, CH_CR});
		send_str({CH_PCT, CH_P, 8'h33, 8'h32, CH_CR});
		send_str({CH_PCT, CH_P, 8'h34});
		send_str({CH_PCT, 8'h51});
		send_str({CH_PCT, CH_P, 8'h31, 8'hb5});
		send_str({CH_PCT, CH_P, 8'h33, 8'h38, CH_CR});
		send_str({CH_PCT, CH_P, 8'h40});
		repeat (10) @(posedge i_clk);
		check(n_rej - r0, 7);
		check(n_req - q0, 0);
		// registered readers are polled without any host request
		cfg(8);
		i_id_registered = 32'h0002_0008;
		@(negedge i_clk);
		check(o_auto_mode, 1'b1);
		check_frame(exp_frame(3, ST_DATA));
		// a host poll in auto mode is dropped and must not break the round robin
		send_str({CH_PCT, CH_P, CH_ZERO, 8'h35, CH_CR});
		check_frame(exp_frame(17, ST_DATA));
		check_frame(exp_frame(3, ST_DATA));
		@(negedge i_clk);
		i_id_registered = 32'h0;
		repeat (400) @(posedge i_clk);
		check(o_auto_mode, 1'b0);
		final_report();
	end
endmodule : tb
